//--- bench/fbf_far_side.sv
/*
  Far-side model: the physical input elements feeding the engine.
  Assumes levels may only move right after a period pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module fbf_far_side (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        pulse_in,
  input  wire logic [15:0] want_in,
  output var  logic [15:0] elem_out
);
  // Change away from the sample strobe, so no capture is ambiguous
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      elem_out <= 16'h0000;
    else if (pulse_in)
      elem_out <= want_in;
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
/*
  Self-checking bench for the function block engine.
  Assumes a short step divider; static slot wiring set at time zero.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fbf_pkg::*;
  localparam int DIV = 10;
  logic        clk_sys_in  = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic [15:0] want        = 16'h0000;
  logic [15:0] in_elem_in;
  logic [8:0]  blk_count_in = 9'h000;
  logic [79:0] src_sel_in  = {5'h18, 5'h18, 5'h04, 5'h04, 5'h03, 5'h02, 5'h10, 5'h10,
                              5'h00, 5'h00, 5'h01, 5'h00, 5'h01, 5'h00, 5'h01, 5'h00};
  logic [15:0] in_inv_in   = 16'h0004;
  logic [7:0]  out_inv_in  = 8'h40;
  logic [15:0] op_sel_in   = 16'h47E4;
  logic [7:0]  mon_en_in   = 8'h00;
  logic [7:0]  sync_lim_in = 8'h01;
  logic [23:0] phys_sel_in = 24'hC00000;
  logic [7:0]  phys_inv_in = 8'h00;
  logic [7:0]  release_out, err_out, phys_out;
  logic [2:0]  period_steps_out;
  logic        period_pulse_out, overload_out;
  int          err_total = 0;
  int          samples_checked = 0;

  fbf_engine #(.STEP_DIV(DIV)) i_fbf_engine (.clk_sys_in, .sys_rst_in, .in_elem_in,
    .blk_count_in, .src_sel_in, .in_inv_in, .out_inv_in, .op_sel_in, .mon_en_in,
    .sync_lim_in, .phys_sel_in, .phys_inv_in, .release_out, .err_out, .phys_out,
    .period_steps_out, .period_pulse_out, .overload_out);
  fbf_far_side i_fbf_far_side (.clk_sys_in, .sys_rst_in, .pulse_in(period_pulse_out),
    .want_in(want), .elem_out(in_elem_in));

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded: a stuck period strobe ends the run
  task automatic wait_pulses(input int n, output int k);
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk_sys_in);
        #1;
        k++;
      end while (period_pulse_out !== 1'b1 && k < 200);
      if (k >= 200) begin
        err_total++;
        final_report();
      end
    end
  endtask

  task automatic t_logic();
    logic [1:0] v;
    logic [7:0] e;
    int         k;
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      @(posedge clk_sys_in);
      want <= {11'h000, v[0], 2'b00, v};
      phys_inv_in <= {4{v}};
      wait_pulses(4, k);
      e = {1'b0, ~v[0], 1'b0, ~(v[0] & v[1]), ~v[0], v[0] ^ v[1], ~v[0] | v[1], v[0] & v[1]};
      chk(release_out, e);
      chk(phys_out, {e[6], {7{e[0]}}} ^ {4{v}});
    end
  endtask

  task automatic t_error();
    int k;
    @(posedge clk_sys_in);
    mon_en_in <= 8'h20;
    want <= 16'h0004;
    wait_pulses(3, k);
    chk(err_out, 8'h00);
    wait_pulses(1, k);
    chk(err_out, 8'h20);
    chk(release_out[5], 1'b0);
    @(posedge clk_sys_in);
    want <= 16'h000C;
    wait_pulses(4, k);
    chk(err_out, 8'h20);
    chk(release_out[5], 1'b0);
    @(posedge clk_sys_in);
    want <= 16'h0000;
    wait_pulses(3, k);
    chk(err_out, 8'h00);
  endtask

  task automatic t_load();
    int k;
    @(posedge clk_sys_in);
    blk_count_in <= 9'h096;
    wait_pulses(2, k);
    wait_pulses(1, k);
    chk(16'(k), 16'(2 * DIV));
    chk(period_steps_out, 3'h2);
    @(posedge clk_sys_in);
    blk_count_in <= 9'h12D;
    @(posedge clk_sys_in);
    #1;
    chk(overload_out, 1'b1);
    wait_pulses(4, k);
    // Clamped load of 300 fills three steps exactly, so no fourth step
    chk(period_steps_out, 3'h3);
    @(posedge clk_sys_in);
    blk_count_in <= 9'h000;
    wait_pulses(4, k);
    chk(period_steps_out, 3'h1);
    chk(overload_out, 1'b0);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1;
    chk({release_out, err_out}, 16'h0000);
    chk(period_steps_out, 3'h1);
    t_logic();
    t_error();
    t_load();
    final_report();
  end
endmodule
`default_nettype wire

//--- core/fbf_engine.sv
/*
  Cyclic execution engine for a small array of logic function block slots.
  Configuration arrives as static ports from the surrounding controller.
*/
// Notes on behaviour
// - Accept up to 300 blocks; load lengthens period
// - Inverted port swaps high and low
// - Period is a whole multiple of 4 ms
// - Overloaded period grows by one 4 ms step; here load clamps at 300, so it stays at three steps
// - Monitored times tolerate 10 ms plus period
// - Period timebase within 100 ppm
// - Inputs come from input elements or blocks
// - One block output fans out widely
// - Error output exists when monitoring is set
// - Error output high on detected fault
// - Error high forces release output low
// - Error clears only on block reset condition
`timescale 1ns/1ps
`default_nettype none
module fbf_engine #(
  parameter int unsigned STEP_DIV = fbf_pkg::STEP_CYCLES
) (
  input  wire logic                                           clk_sys_in,
  input  wire logic                                           sys_rst_in,
  input  wire logic [fbf_pkg::NUM_IN-1:0]                     in_elem_in,
  input  wire logic [8:0]                                     blk_count_in,
  input  wire logic [fbf_pkg::NUM_SLOT*2*fbf_pkg::SRC_W-1:0]  src_sel_in,
  input  wire logic [fbf_pkg::NUM_SLOT*2-1:0]                 in_inv_in,
  input  wire logic [fbf_pkg::NUM_SLOT-1:0]                   out_inv_in,
  input  wire logic [fbf_pkg::NUM_SLOT*2-1:0]                 op_sel_in,
  input  wire logic [fbf_pkg::NUM_SLOT-1:0]                   mon_en_in,
  input  wire logic [7:0]                                     sync_lim_in,
  input  wire logic [fbf_pkg::NUM_PHYS*fbf_pkg::SLOT_W-1:0]   phys_sel_in,
  input  wire logic [fbf_pkg::NUM_PHYS-1:0]                   phys_inv_in,
  output var  logic [fbf_pkg::NUM_SLOT-1:0]                   release_out,
  output var  logic [fbf_pkg::NUM_SLOT-1:0]                   err_out,
  output var  logic [fbf_pkg::NUM_PHYS-1:0]                   phys_out,
  output var  logic [2:0]                                     period_steps_out,
  output var  logic                                           period_pulse_out,
  output var  logic                                           overload_out
);
  import fbf_pkg::*;

  logic                    tick;
  logic [2:0]              step_cnt;
  logic                    exec_stb;
  logic [8:0]              load;
  logic [10:0]             cap_now;
  logic [10:0]             cap_less;
  logic [NUM_IN-1:0]       snap;
  logic [NUM_SLOT-1:0]     res;
  logic [NUM_SLOT-1:0]     next_err;
  logic [NUM_SLOT-1:0]     err_set;
  logic [7:0]              disc [NUM_SLOT];

  // Source decode: 0..15 input elements, 16..23 block outputs
  function automatic logic pick_src(input logic [SRC_W-1:0] sel,
                                    input logic [NUM_IN-1:0] ins,
                                    input logic [NUM_SLOT-1:0] blks);
    logic v;
    v = 1'b0;
    if (sel < SRC_W'(NUM_IN)) begin
      v = ins[sel[3:0]];
    end else if (sel < SRC_W'(NUM_IN + NUM_SLOT)) begin
      v = blks[sel[2:0]];
    end
    return v;
  endfunction

  fbf_tick_gen #(
    .DIV (STEP_DIV)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .tick_out   (tick)
  );

  // Beyond the supported count the load is treated as the maximum
  assign load     = (blk_count_in > MAX_BLOCKS_V) ? MAX_BLOCKS_V : blk_count_in;
  assign cap_now  = 11'(period_steps_out * BLK_PER_STEP);
  assign cap_less = 11'((period_steps_out - 3'h1) * BLK_PER_STEP);
  assign exec_stb = tick && (step_cnt == period_steps_out - 3'h1);

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      step_cnt <= 3'h0;
    end else if (exec_stb) begin
      step_cnt <= 3'h0;
    end else if (tick) begin
      step_cnt <= step_cnt + 3'h1;
    end
  end

  // Length changes only at a period boundary, one step at a time
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      period_steps_out <= STEPS_RST;
    end else if (exec_stb) begin
      if ({2'b00, load} > cap_now && period_steps_out < MAX_STEPS) begin
        period_steps_out <= period_steps_out + 3'h1;
      end else if (period_steps_out > STEPS_RST && {2'b00, load} <= cap_less) begin
        period_steps_out <= period_steps_out - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      overload_out     <= 1'b0;
      period_pulse_out <= 1'b0;
    end else begin
      overload_out     <= blk_count_in > MAX_BLOCKS_V;
      period_pulse_out <= exec_stb;
    end
  end

  // Inputs frozen for the whole period
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      snap <= '0;
    end else if (exec_stb) begin
      snap <= in_elem_in;
    end
  end

  for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
    logic a;
    logic b;
    logic f;
    // Block feedback is last period's release, so chains add one period each
    assign a = pick_src(src_sel_in[(2*s)*SRC_W +: SRC_W], snap, release_out) ^ in_inv_in[2*s];
    assign b = pick_src(src_sel_in[(2*s+1)*SRC_W +: SRC_W], snap, release_out)
               ^ in_inv_in[2*s+1];

    always_comb begin
      unique case (op_sel_in[2*s +: 2])
        OP_AND:  f = a & b;
        OP_OR:   f = a | b;
        OP_XOR:  f = a ^ b;
        OP_NOT:  f = ~a;
      endcase
    end

    // Counted in whole periods: resolution is one period on top of 10 ms
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        disc[s] <= DISC_RST;
      end else if (exec_stb) begin
        if (a == b || !mon_en_in[s]) begin
          disc[s] <= DISC_RST;
        end else if (disc[s] != 8'hFF) begin
          disc[s] <= disc[s] + 8'h01;
        end
      end
    end

    assign err_set[s] = mon_en_in[s] && (a != b) && (disc[s] >= sync_lim_in);

    // Set beats clear; clear needs both inputs back low together, or monitoring off
    always_comb begin
      if (err_set[s]) begin
        next_err[s] = 1'b1;
      end else if (!mon_en_in[s] || (!a && !b)) begin
        next_err[s] = 1'b0;
      end else begin
        next_err[s] = err_out[s];
      end
      res[s] = (f ^ out_inv_in[s]) & ~next_err[s];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      err_out     <= '0;
      release_out <= '0;
    end else if (exec_stb) begin
      err_out     <= next_err;
      release_out <= res;
    end
  end

  for (genvar p = 0; p < NUM_PHYS; p++) begin : g_phys
    // Any release may drive several physical outputs
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        phys_out[p] <= 1'b0;
      end else if (exec_stb) begin
        phys_out[p] <= res[phys_sel_in[p*SLOT_W +: SLOT_W]] ^ phys_inv_in[p];
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_err_blocks_rel: assert property ((err_out & release_out) == '0)
    else $error("release high while error high");
  a_outs_hold_mid: assert property (!exec_stb |=> $stable(release_out) && $stable(err_out))
    else $error("outputs changed inside a period");
  a_steps_range: assert property (period_steps_out >= STEPS_RST && period_steps_out <= MAX_STEPS)
    else $error("period steps out of range");
  a_steps_grow: assert property (exec_stb && {2'b00, load} > cap_now && period_steps_out < MAX_STEPS
    |=> period_steps_out == $past(period_steps_out) + 3'h1)
    else $error("period did not grow under overload");
  a_stb_on_tick: assert property (exec_stb |-> tick && step_cnt < period_steps_out)
    else $error("execution strobe off the step grid");
  a_overload_flag: assert property (blk_count_in > MAX_BLOCKS_V |=> overload_out)
    else $error("excess block count not flagged");
  a_err_set_now: assert property (exec_stb && err_set[0] |=> err_out[0] && !release_out[0])
    else $error("fault did not raise error");
  a_err_sticky: assert property (err_out[0] && mon_en_in[0] && exec_stb && (g_slot[0].a || g_slot[0].b)
    |=> err_out[0])
    else $error("error cleared without reset condition");
  a_snap_take: assert property (exec_stb |=> snap == $past(in_elem_in))
    else $error("inputs not sampled at period start");

  c_err_raise: cover property (exec_stb && err_set[0]);
  c_period_grow: cover property (exec_stb && period_steps_out == 3'h1 ##1 period_steps_out == 3'h2);
  c_release_high: cover property (release_out[0] ##1 period_pulse_out);
endmodule
`default_nettype wire

//--- core/fbf_pkg.sv
/*
  Shared constants for the function block execution framework.
  Assumes a 125 MHz system clock.
*/
package fbf_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned STEP_MS       = 4;
  localparam int unsigned STEP_CYCLES   = (STEP_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int unsigned MAX_BLOCKS    = 300;
  localparam logic [8:0]  MAX_BLOCKS_V  = 9'(MAX_BLOCKS);
  localparam logic [10:0] BLK_PER_STEP  = 11'd100;
  localparam logic [2:0]  MAX_STEPS     = 3'h4;
  localparam logic [2:0]  STEPS_RST     = 3'h1;
  localparam int unsigned NUM_IN        = 16;
  localparam int unsigned NUM_SLOT      = 8;
  localparam int unsigned NUM_PHYS      = 8;
  localparam int unsigned SRC_W         = 5;
  localparam int unsigned SLOT_W        = 3;
  localparam logic [1:0]  OP_AND        = 2'h0;
  localparam logic [1:0]  OP_OR         = 2'h1;
  localparam logic [1:0]  OP_XOR        = 2'h2;
  localparam logic [1:0]  OP_NOT        = 2'h3;
  localparam logic [7:0]  DISC_RST      = 8'h00;
endpackage

//--- core/fbf_tick_gen.sv
/*
  Divider giving one-cycle pulses at the 4 ms execution step.
  Assumes the system clock itself meets the timebase accuracy.
*/
`timescale 1ns/1ps
`default_nettype none
module fbf_tick_gen #(
  parameter int unsigned DIV = fbf_pkg::STEP_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  output var  logic tick_out
);
  import fbf_pkg::*;

  logic [19:0] cnt;

  // Timebase error is purely the clock's; no trimming here
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt      <= 20'h00000;
      tick_out <= 1'b0;
    end else if (cnt == 20'(DIV - 1)) begin
      cnt      <= 20'h00000;
      tick_out <= 1'b1;
    end else begin
      cnt      <= cnt + 20'h00001;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire
